// ---- shared/capture_regs_pkg.sv ----
package capture_regs_pkg;
  // ==========================================
  // Register addresses and pages
  localparam logic [7:0] MODE_ADDR = 8'hDA;
  localparam logic [7:0] VALUE_LOW_ADDR = 8'hFB;
  localparam logic [7:0] VALUE_HIGH_ADDR = 8'hFC;
  localparam logic [7:0] PAGE_BASE = 8'h00;
  localparam logic [7:0] PAGE_ALT = 8'h10;
  // ==========================================
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  // ==========================================
  // Mode register field positions
  localparam int WIDE_PWM_BIT = 7;
  localparam int COMPARATOR_BIT = 6;
  localparam int RISING_BIT = 5;
  localparam int FALLING_BIT = 4;
  localparam int MATCH_BIT = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int PWM_BIT = 1;
  localparam int FLAG_IRQ_BIT = 0;
  // ==========================================
  // Register selection
  typedef enum {SEL_NONE, SEL_MODE, SEL_LOW, SEL_HIGH} reg_sel_e;
endpackage : capture_regs_pkg

// ---- logic/sfr_decode.sv ----
`timescale 1ns/1ns
// ==========================================
// Address and page decode for the channel registers
module sfr_decode
(
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrPage,
  output capture_regs_pkg::reg_sel_e regSel
);
  import capture_regs_pkg::*;
  // Registers answer on both pages
  always_comb
  begin
    regSel = SEL_NONE;
    if (sfrPage == PAGE_BASE || sfrPage == PAGE_ALT)
    begin
      case (sfrAddr)
        MODE_ADDR: regSel = SEL_MODE;
        VALUE_LOW_ADDR: regSel = SEL_LOW;
        VALUE_HIGH_ADDR: regSel = SEL_HIGH;
        default: regSel = SEL_NONE;
      endcase
    end
  end
endmodule : sfr_decode

// ---- logic/capture_channel_zero_regs.sv ----
// Notes on behaviour
// - Low value byte holds compare bits 7:0, read/write, resets to zero.
// - High value byte holds compare bits 15:8, read/write, resets to zero.
// - Low address alternatively reaches auto-reload low byte for 9-11 bit PWM.
// - High address alternatively reaches auto-reload high byte.
// - Auto-reload select bit chooses compare bytes or auto-reload bytes.
// - Any write to the low address clears comparator enable.
// - Any write to the high address sets comparator enable.
// - High byte decoded at 0xFC on pages 0x0 and 0x10.
`timescale 1ns/1ns
// ==========================================
// Register file of capture channel zero
module capture_channel_zero_regs
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrPage,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWriteData,
  output logic [7:0] sfrReadData,
  output logic sfrReadHit,
  input wire logic autoReloadSelect,
  output logic [15:0] compareValue,
  output logic [15:0] autoReloadValue,
  output logic widePwmSelect,
  output logic comparatorEnable,
  output logic risingCaptureEnable,
  output logic fallingCaptureEnable,
  output logic matchEnable,
  output logic toggleEnable,
  output logic pwmEnable,
  output logic flagInterruptEnable
);
  import capture_regs_pkg::*;

  // ==========================================
  // Helper functions
  // Replace one byte of a 16-bit value, keeping the other byte
  function automatic logic [15:0] merge_byte(
    input logic [15:0] value,
    input logic [7:0] data,
    input logic upper
  );
    logic [15:0] merged;
    merged = value;
    if (upper)
      merged[15:8] = data;
    else
      merged[7:0] = data;
    return merged;
  endfunction : merge_byte

  // One byte of a 16-bit value for the read path
  function automatic logic [7:0] pick_byte(
    input logic [15:0] value,
    input logic upper
  );
    return upper ? value[15:8] : value[7:0];
  endfunction : pick_byte

  // High lane address of the value pair
  function automatic logic is_high_byte(input reg_sel_e sel);
    return sel == SEL_HIGH;
  endfunction : is_high_byte

  // Either address of the value pair
  function automatic logic is_value_reg(input reg_sel_e sel);
    return sel == SEL_LOW || sel == SEL_HIGH;
  endfunction : is_value_reg

  // ==========================================
  // Decode
  reg_sel_e regSel;
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [15:0] next_compareValue;
  logic [15:0] next_autoReloadValue;
  logic [7:0] next_sfrReadData;
  logic next_sfrReadHit;
  logic valueWrite;
  logic compareWrite;
  logic reloadWrite;
  logic upperLane;

  sfr_decode decoder (
    .sfrAddr(sfrAddr),
    .sfrPage(sfrPage),
    .regSel(regSel)
  );

  // ==========================================
  // Value register strobes
  // Select bit decides which byte pair a value write lands in
  assign valueWrite = sfrWrite && is_value_reg(regSel);
  assign upperLane = is_high_byte(regSel);
  assign compareWrite = valueWrite && !autoReloadSelect;
  assign reloadWrite = valueWrite && autoReloadSelect;

  // ==========================================
  // Mode register
  // Software write, or comparator enable forced by a value write;
  // only one address per cycle, so the two never collide
  always_comb
  begin
    next_mode = mode;
    if (sfrWrite)
    begin
      case (regSel)
        SEL_MODE: next_mode = sfrWriteData;
        SEL_LOW: next_mode[COMPARATOR_BIT] = 1'h0;
        SEL_HIGH: next_mode[COMPARATOR_BIT] = 1'h1;
        default: next_mode = mode;
      endcase
    end
  end

  // Mode flops, all enables off after reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mode <= MODE_RESET;
    else
      mode <= next_mode;
  end

  // ==========================================
  // Capture/compare value
  // Byte write when the select bit points at the compare pair
  always_comb
  begin
    next_compareValue = compareValue;
    if (compareWrite)
      next_compareValue = merge_byte(compareValue, sfrWriteData,
        upperLane);
  end

  // Compare flops; the channel sees the new byte one cycle on
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      compareValue <= {VALUE_RESET, VALUE_RESET};
    else
      compareValue <= next_compareValue;
  end

  // ==========================================
  // Auto-reload value
  // Byte write when the select bit points at the reload pair
  always_comb
  begin
    next_autoReloadValue = autoReloadValue;
    if (reloadWrite)
      next_autoReloadValue = merge_byte(autoReloadValue, sfrWriteData,
        upperLane);
  end

  // Reload flops, cleared with the rest of the channel
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      autoReloadValue <= {VALUE_RESET, VALUE_RESET};
    else
      autoReloadValue <= next_autoReloadValue;
  end

  // ==========================================
  // Read return
  // Old contents come back when a write hits the same cycle;
  // unmapped or idle cycles return zero so a shared bus stays clean
  always_comb
  begin
    next_sfrReadData = VALUE_RESET;
    next_sfrReadHit = 1'h0;
    if (sfrRead)
    begin
      case (regSel)
        SEL_MODE:
        begin
          next_sfrReadData = mode;
          next_sfrReadHit = 1'h1;
        end
        SEL_LOW, SEL_HIGH:
        begin
          if (autoReloadSelect)
            next_sfrReadData = pick_byte(autoReloadValue, upperLane);
          else
            next_sfrReadData = pick_byte(compareValue, upperLane);
          next_sfrReadHit = 1'h1;
        end
        default:
        begin
          next_sfrReadData = VALUE_RESET;
          next_sfrReadHit = 1'h0;
        end
      endcase
    end
  end

  // Read flops, each answer stands for one cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sfrReadData <= VALUE_RESET;
      sfrReadHit <= 1'h0;
    end
    else
    begin
      sfrReadData <= next_sfrReadData;
      sfrReadHit <= next_sfrReadHit;
    end
  end

  // ==========================================
  // Mode fields to the channel
  assign widePwmSelect = mode[WIDE_PWM_BIT];
  assign comparatorEnable = mode[COMPARATOR_BIT];
  assign risingCaptureEnable = mode[RISING_BIT];
  assign fallingCaptureEnable = mode[FALLING_BIT];
  assign matchEnable = mode[MATCH_BIT];
  assign toggleEnable = mode[TOGGLE_BIT];
  assign pwmEnable = mode[PWM_BIT];
  assign flagInterruptEnable = mode[FLAG_IRQ_BIT];
endmodule : capture_channel_zero_regs

// ---- testbench/capture_zero_props.sv ----
`timescale 1ns/1ns
// ==========================================
// Value register write checks
module capture_zero_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrPage,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWriteData,
  input wire logic autoReloadSelect,
  input wire logic [15:0] compareValue,
  input wire logic [15:0] autoReloadValue,
  input wire logic comparatorEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Page hit and write sequences
  wire pageOk = sfrPage == 8'h00 || sfrPage == 8'h10;
  sequence wrLow; sfrWrite && pageOk && sfrAddr == 8'hFB; endsequence
  sequence wrHigh; sfrWrite && pageOk && sfrAddr == 8'hFC; endsequence
  AST_LOW_CMP: assert property (wrLow ##0 !autoReloadSelect |=>
    compareValue[7:0] == $past(sfrWriteData)) else $error("low lost");
  AST_HIGH_CMP: assert property (wrHigh ##0 !autoReloadSelect |=>
    compareValue[15:8] == $past(sfrWriteData)) else $error("high lost");
  AST_LOW_AR: assert property (wrLow ##0 autoReloadSelect |=>
    autoReloadValue[7:0] == $past(sfrWriteData)) else $error("arl lost");
  AST_HIGH_AR: assert property (wrHigh ##0 autoReloadSelect |=>
    autoReloadValue[15:8] == $past(sfrWriteData)) else $error("arh lost");
  AST_SEL_HOLD: assert property (wrLow ##0 autoReloadSelect |=>
    $stable(compareValue)) else $error("compare hit");
  AST_COMPARATOR_ENABLE_CLR: assert property (wrLow |=> !comparatorEnable)
    else $error("enable kept");
  AST_COMPARATOR_ENABLE_SET: assert property (wrHigh |=> comparatorEnable)
    else $error("enable not set");
  AST_PAGE: assert property (sfrWrite && !pageOk |=>
    $stable(compareValue)) else $error("bad page hit");
endmodule : capture_zero_props
bind capture_channel_zero_regs capture_zero_props u_props (.clk, .sys_rst,
  .sfrAddr, .sfrPage, .sfrWrite, .sfrWriteData, .autoReloadSelect,
  .compareValue, .autoReloadValue, .comparatorEnable);

// ---- testbench/capture_channel_zero_regs_tb.sv ----
`timescale 1ns/1ns
module capture_channel_zero_regs_tb;
  logic clk = 1'h0, sys_rst = 1'h1, sfrWrite = 1'h0, sfrRead = 1'h0;
  logic autoReloadSelect = 1'h0, hit;
  logic [7:0] modePins;
  logic [7:0] sfrAddr = 8'h00, sfrPage = 8'h00, wData = 8'h00, rData;
  logic [15:0] cmp, arv;
  int badCount = 0, totalChecks = 0, cycles = 0;
  capture_channel_zero_regs u_dut (.clk, .sys_rst, .sfrAddr, .sfrPage,
    .sfrWrite, .sfrRead, .sfrWriteData(wData), .sfrReadData(rData),
    .sfrReadHit(hit), .autoReloadSelect, .compareValue(cmp),
    .autoReloadValue(arv), .widePwmSelect(modePins[7]),
    .comparatorEnable(modePins[6]), .risingCaptureEnable(modePins[5]),
    .fallingCaptureEnable(modePins[4]), .matchEnable(modePins[3]),
    .toggleEnable(modePins[2]), .pwmEnable(modePins[1]),
    .flagInterruptEnable(modePins[0]));
  // Free-running 25 MHz clock
  always #20 clk = ~clk;
  // ==========================================
  // Hang guard, far above the eighty or so cycles the scenarios need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      badCount++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (badCount == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // Compare one value and count it
  task automatic chk(input string n, input logic [15:0] seen, exp);
    totalChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // One-cycle write strobe, launched at a falling edge
  task automatic wr(input logic [7:0] a, p, d);
    @(negedge clk);
    {sfrAddr, sfrPage, wData, sfrWrite} = {a, p, d, 1'h1};
    @(negedge clk);
    sfrWrite = 1'h0;
  endtask : wr
  // One-cycle read strobe; the answer is judged while it stands
  task automatic rd(input logic [7:0] a, p, e, input logic h);
    @(negedge clk);
    {sfrAddr, sfrPage, sfrRead} = {a, p, 1'h1};
    @(negedge clk);
    sfrRead = 1'h0;
    chk("rdata", {8'h00, rData}, {8'h00, e});
    chk("hit", {15'h0, hit}, {15'h0, h});
  endtask : rd
  // ==========================================
  // Scenarios
  // Values straight out of reset
  task automatic check_reset_state();
    chk("cmp", cmp, 16'h0000);
    chk("arv", arv, 16'h0000);
    chk("pins", {8'h00, modePins}, 16'h0000);
    rd(8'hDA, 8'h00, 8'h00, 1'h1);
    rd(8'hFB, 8'h10, 8'h00, 1'h1);
    rd(8'hFC, 8'h00, 8'h00, 1'h1);
  endtask : check_reset_state
  // Compare bytes and the comparator enable side effects
  task automatic check_compare_bytes();
    wr(8'hFB, 8'h00, 8'h5A);
    chk("comparator_enable", {15'h0, modePins[6]}, 16'h0000);
    wr(8'hFC, 8'h10, 8'hC3);
    chk("comparator_enable", {15'h0, modePins[6]}, 16'h0001);
    chk("cmp", cmp, 16'hC35A);
    rd(8'hFC, 8'h10, 8'hC3, 1'h1);
    rd(8'hFB, 8'h10, 8'h5A, 1'h1);
  endtask : check_compare_bytes
  // Auto-reload bytes behind the same addresses
  task automatic check_auto_reload();
    autoReloadSelect = 1'h1;
    wr(8'hFB, 8'h00, 8'h11);
    chk("comparator_enable", {15'h0, modePins[6]}, 16'h0000);
    wr(8'hFC, 8'h00, 8'h22);
    chk("comparator_enable", {15'h0, modePins[6]}, 16'h0001);
    chk("arv", arv, 16'h2211);
    chk("cmp", cmp, 16'hC35A);
    rd(8'hFB, 8'h00, 8'h11, 1'h1);
    rd(8'hFC, 8'h10, 8'h22, 1'h1);
    autoReloadSelect = 1'h0;
    rd(8'hFB, 8'h00, 8'h5A, 1'h1);
    chk("arv", arv, 16'h2211);
  endtask : check_auto_reload
  // Mode bits, their pins and the forced enable
  task automatic check_mode_bits();
    wr(8'hDA, 8'h10, 8'hE5);
    rd(8'hDA, 8'h00, 8'hE5, 1'h1);
    chk("pins", {8'h00, modePins}, 16'h00E5);
    wr(8'hFB, 8'h00, 8'h00);
    rd(8'hDA, 8'h10, 8'hA5, 1'h1);
    chk("cmp", cmp, 16'hC300);
    wr(8'hDA, 8'h00, 8'h1A);
    chk("pins", {8'h00, modePins}, 16'h001A);
    wr(8'hFC, 8'h00, 8'hC3);
    chk("pins", {8'h00, modePins}, 16'h005A);
    chk("cmp", cmp, 16'hC300);
  endtask : check_mode_bits
  // Writes and reads outside the decoded addresses and pages
  task automatic check_refused();
    wr(8'hFB, 8'h20, 8'h77);
    chk("comparator_enable", {15'h0, modePins[6]}, 16'h0001);
    chk("cmp", cmp, 16'hC300);
    wr(8'hDB, 8'h00, 8'hFF);
    chk("pins", {8'h00, modePins}, 16'h005A);
    wr(8'hDA, 8'h20, 8'h00);
    chk("pins", {8'h00, modePins}, 16'h005A);
    wr(8'hFB, 8'h00, 8'h00);
    wr(8'hFC, 8'h20, 8'h77);
    chk("comparator_enable", {15'h0, modePins[6]}, 16'h0000);
    chk("cmp", cmp, 16'hC300);
    rd(8'hFC, 8'h20, 8'h00, 1'h0);
    rd(8'hDB, 8'h00, 8'h00, 1'h0);
  endtask : check_refused
  // Second reset in mid-run clears everything again
  task automatic check_reset_again();
    wr(8'hDA, 8'h00, 8'hFF);
    chk("pins", {8'h00, modePins}, 16'h00FF);
    @(negedge clk);
    sys_rst = 1'h1;
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    check_reset_state();
  endtask : check_reset_again
  // Run order
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    check_reset_state();
    check_compare_bytes();
    check_auto_reload();
    check_mode_bits();
    check_refused();
    check_reset_again();
    report_and_stop();
  end
endmodule : capture_channel_zero_regs_tb
